// ---- design/lpmc_top.sv ----
// pump gain stepping, soft start, operating modes and backlight levels
// assumes an outside receiver turns serial commands into register pulses
// Notes on behaviour
// [RQ1] pump starts in unity gain after soft start
// [RQ2] enabled sink below headroom raises gain one step
// [RQ3] wait settle interval after every gain change
// [RQ4] still short at 1.5x steps up to 2x
// [RQ5] all headroom above downstep threshold lowers gain
// [RQ6] disabled sinks ignored in gain decisions
// [RQ7] series or parallel charge, parallel discharge phases
// [RQ8] fault opens every pump switch
// [RQ9] limited charge until output ready, then unity
// [RQ10] standby exit or fault recovery reruns soft start
// [RQ11] active bit one enables active mode
// [RQ12] standby from active bit zero or reset pin
// [RQ13] undervoltage shuts down, recovery resets into standby
// [RQ14] leaving shutdown resets registers, enters standby
// [RQ15] reset pin low holds defaults, no acknowledge
// [RQ16] after pin release defaults kept, commands accepted
// [RQ17] reset pin must stay low whole filter time
// [RQ18] backlight uses maximum or dim level register
// [RQ19] levels are seven bit codes, 128 steps
// [RQ20] dim code is never clamped to maximum
// [RQ21] law zero is linear, code times 127
// [RQ22] law one is square, code squared
// [RQ23] dim select picks dim, clearing returns maximum
// [RQ24] standby, shutdown or reset returns to soft start
`timescale 1ns/1ps
module lpmc_top #(
	parameter int SettleCycles = lpmc_pkg::SETTLE_US * lpmc_pkg::CLK_MHZ
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 resetPinLowN,
	input  wire logic                 undervoltageLockout,
	input  wire lpmc_pkg::lpmc_sense_t sense,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	input  wire logic [7:0]           regAddr,
	input  wire logic [7:0]           regWdata,
	output logic [7:0]                regRdata,
	output logic                      regAck,
	output logic [1:0]                pumpGain,
	output logic                      softStartOn,
	output lpmc_pkg::lpmc_switch_t    pumpSwitch,
	output logic [6:0]                levelCode,
	output logic [13:0]               sinkCurrent
);
	lpmc_pkg::lpmc_state_t q;
	lpmc_pkg::lpmc_state_t d;
	logic                  blocked;
	logic                  upNeed;
	logic                  downOk;
	logic                  restart;

	// local copies of the package widths so the size casts stay unscoped
	localparam int FILTER_W = lpmc_pkg::FILTER_W;
	localparam int SETTLE_W = lpmc_pkg::SETTLE_W;
	localparam int PHASE_W  = lpmc_pkg::PHASE_W;

	function automatic logic [7:0] readReg(
		input logic [7:0]            addr,
		input lpmc_pkg::lpmc_state_t s
	);
		logic [7:0] v;
		v = lpmc_pkg::REG_RESET;
		case (addr)
			lpmc_pkg::ADDR_MODE: v[lpmc_pkg::ACTIVE_BIT] = s.active;
			lpmc_pkg::ADDR_BL: begin
				v[lpmc_pkg::BLON_BIT]   = s.blOn;
				v[lpmc_pkg::DIMSEL_BIT] = s.dimSel;
			end
			lpmc_pkg::ADDR_LAW:  v[1:0] = s.law;
			lpmc_pkg::ADDR_SINK: v[6:0] = s.sinkEn;
			lpmc_pkg::ADDR_MAX:  v[6:0] = s.maxLvl;
			lpmc_pkg::ADDR_DIM:  v[6:0] = s.dimLvl;
			default:             v = lpmc_pkg::REG_RESET;
		endcase
		return v;
	endfunction

	// shutdown and a filtered pin reset both keep the registers cleared
	assign blocked = q.uvS[1] | q.pinRst; // [RQ13] [RQ15]
	assign upNeed  = |(q.lowS2 & q.sinkEn); // [RQ6]
	assign downOk  = &(q.highS2 | ~q.sinkEn); // [RQ5] [RQ6]
	assign restart = regWrite && !blocked && regAddr == lpmc_pkg::ADDR_MODE
		&& regWdata[lpmc_pkg::ACTIVE_BIT];

	always_comb begin
		d = q;
		d.pinS   = {q.pinS[0], resetPinLowN};
		d.uvS    = {q.uvS[0], undervoltageLockout};
		d.fltS   = {q.fltS[0], sense.fault};
		d.rdyS   = {q.rdyS[0], sense.outputReady};
		d.lowS1  = sense.sinkLow;
		d.lowS2  = q.lowS1;
		d.highS1 = sense.sinkHigh;
		d.highS2 = q.highS1;

		// pin must read low for the whole filter interval
		if (q.pinS[1]) begin
			d.pinCnt = '0;
			d.pinRst = 1'b0; // [RQ16]
		end else if (q.pinCnt == FILTER_W'(lpmc_pkg::FILTER_CYCLES - 1)) begin
			d.pinRst = 1'b1; // [RQ17] [RQ12]
		end else begin
			d.pinCnt = q.pinCnt + 1'b1; // [RQ17]
		end

		d.ack   = (regWrite | regRead) && !blocked; // [RQ15] [RQ16]
		d.rdata = regRead ? readReg(regAddr, q) : q.rdata;
		if (regWrite && !blocked) begin
			case (regAddr)
				lpmc_pkg::ADDR_MODE:
					d.active = regWdata[lpmc_pkg::ACTIVE_BIT]; // [RQ11]
				lpmc_pkg::ADDR_BL: begin
					d.blOn   = regWdata[lpmc_pkg::BLON_BIT];
					d.dimSel = regWdata[lpmc_pkg::DIMSEL_BIT]; // [RQ23]
				end
				lpmc_pkg::ADDR_LAW:  d.law    = regWdata[1:0];
				lpmc_pkg::ADDR_SINK: d.sinkEn = regWdata[6:0];
				lpmc_pkg::ADDR_MAX:  d.maxLvl = regWdata[6:0]; // [RQ19]
				lpmc_pkg::ADDR_DIM:  d.dimLvl = regWdata[6:0]; // [RQ20]
				default: d.active = q.active;
			endcase
		end
		if (blocked) begin
			d.active = 1'b0; // [RQ14] [RQ13]
			d.blOn   = 1'b0;
			d.dimSel = 1'b0;
			d.law    = lpmc_pkg::LAW_LINEAR; // [RQ21]
			d.sinkEn = '0;
			d.maxLvl = '0;
			d.dimLvl = '0;
			d.rdata  = lpmc_pkg::REG_RESET;
		end

		// any stop sends the pump back through soft start
		if (!q.active || blocked) begin
			d.pump   = lpmc_pkg::PUMP_OFF; // [RQ24] [RQ12]
			d.settle = '0;
		end else begin
			case (q.pump)
				lpmc_pkg::PUMP_OFF: d.pump = lpmc_pkg::PUMP_SOFT; // [RQ10]
				lpmc_pkg::PUMP_SOFT: begin
					if (q.fltS[1]) begin
						d.pump = lpmc_pkg::PUMP_FAULT;
					end else if (q.rdyS[1]) begin
						d.pump   = lpmc_pkg::PUMP_G1; // [RQ9] [RQ1]
						d.settle = SETTLE_W'(SettleCycles - 1);
					end
				end
				lpmc_pkg::PUMP_G1, lpmc_pkg::PUMP_G15, lpmc_pkg::PUMP_G2: begin
					if (q.fltS[1]) begin
						d.pump = lpmc_pkg::PUMP_FAULT; // [RQ8]
					end else if (q.settle != '0) begin
						d.settle = q.settle - 1'b1; // [RQ3]
					end else if (upNeed && q.pump != lpmc_pkg::PUMP_G2) begin
						d.pump = (q.pump == lpmc_pkg::PUMP_G1) ?
							lpmc_pkg::PUMP_G15 : lpmc_pkg::PUMP_G2; // [RQ2] [RQ4]
						d.settle = SETTLE_W'(SettleCycles - 1); // [RQ3]
					end else if (!upNeed && downOk
						&& q.pump != lpmc_pkg::PUMP_G1) begin
						d.pump = (q.pump == lpmc_pkg::PUMP_G2) ?
							lpmc_pkg::PUMP_G15 : lpmc_pkg::PUMP_G1; // [RQ5]
						d.settle = SETTLE_W'(SettleCycles - 1); // [RQ3]
					end
				end
				lpmc_pkg::PUMP_FAULT: begin
					// only a fresh enable write restarts after a fault
					if (restart && !q.fltS[1])
						d.pump = lpmc_pkg::PUMP_SOFT; // [RQ10]
				end
				default: d.pump = lpmc_pkg::PUMP_OFF;
			endcase
		end

		if (q.phCnt == PHASE_W'(lpmc_pkg::PHASE_CYCLES - 1)) begin
			d.phCnt = '0;
			d.phase = ~q.phase; // [RQ7]
		end else begin
			d.phCnt = q.phCnt + 1'b1;
		end

		if (q.active && q.blOn)
			d.level = q.dimSel ? q.dimLvl : q.maxLvl; // [RQ18] [RQ23] [RQ20]
		else
			d.level = '0;
		// current in steps of full scale / 16129 for both laws
		if (q.law == lpmc_pkg::LAW_LINEAR)
			d.current = 14'(q.level) * 14'(lpmc_pkg::LEVEL_FULL); // [RQ21]
		else
			d.current = 14'(q.level) * 14'(q.level); // [RQ22]
	end

	always_ff @(posedge mclk) begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	always_comb begin
		pumpSwitch  = '0;
		pumpGain    = lpmc_pkg::GAIN_NONE;
		softStartOn = q.pump == lpmc_pkg::PUMP_SOFT; // [RQ9]
		case (q.pump)
			lpmc_pkg::PUMP_G1: begin
				pumpGain          = lpmc_pkg::GAIN_1X;
				pumpSwitch.bypass = 1'b1; // [RQ1]
			end
			lpmc_pkg::PUMP_G15: begin
				pumpGain                     = lpmc_pkg::GAIN_15X;
				pumpSwitch.chargeSeries      = ~q.phase; // [RQ7]
				pumpSwitch.dischargeParallel = q.phase;
			end
			lpmc_pkg::PUMP_G2: begin
				pumpGain                     = lpmc_pkg::GAIN_2X;
				pumpSwitch.chargeParallel    = ~q.phase; // [RQ7]
				pumpSwitch.dischargeParallel = q.phase;
			end
			// off, soft start and fault leave every switch open
			default: pumpSwitch = '0; // [RQ8]
		endcase
	end

	assign regRdata    = q.rdata;
	assign regAck      = q.ack;
	assign levelCode   = q.level;
	assign sinkCurrent = q.current;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_soft_to_unity: assert property ( // [RQ9]
		q.pump == lpmc_pkg::PUMP_SOFT && q.active && !blocked
		&& !q.fltS[1] && q.rdyS[1] |=> pumpGain == lpmc_pkg::GAIN_1X
		&& pumpSwitch.bypass) else $error("soft start did not reach unity");
	a_settle_gate: assert property ( // [RQ3]
		q.pump != $past(q.pump) && q.pump inside {lpmc_pkg::PUMP_G15,
		lpmc_pkg::PUMP_G2} |-> $past(q.settle) == '0
		|| $past(q.pump) == lpmc_pkg::PUMP_SOFT)
		else $error("gain changed before settling");
	a_step_up: assert property ( // [RQ2]
		q.pump == lpmc_pkg::PUMP_G1 && q.settle == '0 && upNeed
		&& q.active && !blocked && !q.fltS[1]
		|=> q.pump == lpmc_pkg::PUMP_G15) else $error("no step to 1.5x");
	a_step_two: assert property ( // [RQ4]
		q.pump == lpmc_pkg::PUMP_G15 && q.settle == '0 && upNeed
		&& q.active && !blocked && !q.fltS[1]
		|=> pumpGain == lpmc_pkg::GAIN_2X) else $error("no step to 2x");
	a_step_down: assert property ( // [RQ5]
		q.pump == lpmc_pkg::PUMP_G2 && q.settle == '0 && !upNeed && downOk
		&& q.active && !blocked && !q.fltS[1]
		|=> q.pump == lpmc_pkg::PUMP_G15) else $error("no step down");
	a_ignore_disabled: assert property ( // [RQ6]
		q.pump == lpmc_pkg::PUMP_G1 && (q.lowS2 & q.sinkEn) == '0
		&& q.active && !blocked |=> q.pump != lpmc_pkg::PUMP_G15)
		else $error("disabled sink raised gain");
	a_fault_isolate: assert property ( // [RQ8]
		q.fltS[1] && q.active && !blocked |=> pumpSwitch == '0 [*2])
		else $error("switches closed during fault");
	a_standby_soft: assert property ( // [RQ24]
		!q.active |=> q.pump == lpmc_pkg::PUMP_OFF ##1
		(q.pump == lpmc_pkg::PUMP_OFF || q.pump == lpmc_pkg::PUMP_SOFT))
		else $error("pump left soft start path");
	a_reset_hold: assert property ( // [RQ15]
		q.pinRst && $past(q.pinRst) |-> !regAck && q.maxLvl == '0
		&& !q.active) else $error("registers or ack live in reset");
	a_filter_len: assert property ( // [RQ17]
		$rose(q.pinRst) |-> $past(q.pinCnt)
		== FILTER_W'(lpmc_pkg::FILTER_CYCLES - 1) && !$past(q.pinS[1]))
		else $error("reset pin filter too short");
	a_level_select: assert property ( // [RQ23]
		q.active && q.blOn && !q.dimSel |=> levelCode == $past(q.maxLvl))
		else $error("maximum level not chosen");
	a_square_law: assert property ( // [RQ22]
		q.law == lpmc_pkg::LAW_SQUARE |=> sinkCurrent
		== 14'($past(q.level)) * 14'($past(q.level)))
		else $error("square law current wrong");
endmodule

// ---- include/lpmc_pkg.sv ----
// package for the led pump mode and level control block
// assumes a 50 MHz mclk and comparator levels arriving unsynchronised
package lpmc_pkg;
	localparam int CLK_MHZ       = 50;
	localparam int SETTLE_US     = 100;
	localparam int FILTER_US     = 50;
	localparam int FILTER_CYCLES = FILTER_US * CLK_MHZ;
	// pump switch phase length, one phase per microsecond half
	localparam int PHASE_CYCLES  = 25;
	localparam int SINKS         = 7;
	localparam int SETTLE_W      = 13;
	localparam int FILTER_W      = 12;
	localparam int PHASE_W       = 5;

	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_BL   = 8'h01;
	localparam logic [7:0] ADDR_LAW  = 8'h04;
	localparam logic [7:0] ADDR_SINK = 8'h05;
	localparam logic [7:0] ADDR_MAX  = 8'h09;
	localparam logic [7:0] ADDR_DIM  = 8'h0A;

	localparam int ACTIVE_BIT = 0;
	localparam int BLON_BIT   = 0;
	localparam int DIMSEL_BIT = 1;

	localparam logic [1:0] LAW_LINEAR = 2'h0;
	localparam logic [1:0] LAW_SQUARE = 2'h1;
	localparam logic [6:0] LEVEL_FULL = 7'h7F;
	localparam logic [7:0] REG_RESET  = 8'h00;

	localparam logic [1:0] GAIN_NONE = 2'h0;
	localparam logic [1:0] GAIN_1X   = 2'h1;
	localparam logic [1:0] GAIN_15X  = 2'h2;
	localparam logic [1:0] GAIN_2X   = 2'h3;

	typedef enum logic [2:0] {
		PUMP_OFF, PUMP_SOFT, PUMP_G1, PUMP_G15, PUMP_G2, PUMP_FAULT
	} lpmc_pump_t;

	typedef struct packed {
		logic bypass;
		logic chargeSeries;
		logic chargeParallel;
		logic dischargeParallel;
	} lpmc_switch_t;

	typedef struct packed {
		logic [SINKS-1:0] sinkLow;
		logic [SINKS-1:0] sinkHigh;
		logic             outputReady;
		logic             fault;
	} lpmc_sense_t;

	typedef struct packed {
		logic [1:0]          pinS;
		logic [1:0]          uvS;
		logic [1:0]          fltS;
		logic [1:0]          rdyS;
		logic [SINKS-1:0]    lowS1;
		logic [SINKS-1:0]    lowS2;
		logic [SINKS-1:0]    highS1;
		logic [SINKS-1:0]    highS2;
		logic [FILTER_W-1:0] pinCnt;
		logic                pinRst;
		lpmc_pump_t          pump;
		logic [SETTLE_W-1:0] settle;
		logic [PHASE_W-1:0]  phCnt;
		logic                phase;
		logic                active;
		logic                blOn;
		logic                dimSel;
		logic [1:0]          law;
		logic [SINKS-1:0]    sinkEn;
		logic [6:0]          maxLvl;
		logic [6:0]          dimLvl;
		logic [7:0]          rdata;
		logic                ack;
		logic [6:0]          level;
		logic [13:0]         current;
	} lpmc_state_t;
endpackage

// ---- tb/lpmc_pump_model.sv ----
// behavioural model of the analog pump stage and sink comparators
// assumes need and shortMask come from the bench, settled before use
`timescale 1ns/1ps
module lpmc_pump_model (
	input  wire logic                       mclk,
	input  wire logic [1:0]                 pumpGain,
	input  wire logic                       softStartOn,
	input  wire logic [1:0]                 need,
	input  wire logic [lpmc_pkg::SINKS-1:0] shortMask,
	input  wire logic                       faultIn,
	output lpmc_pkg::lpmc_sense_t           sense
);
	logic [3:0] rdyCnt;

	// output climbs for ten cycles under limited current
	always_ff @(posedge mclk) begin
		if (!softStartOn)
			rdyCnt <= 4'h0;
		else if (rdyCnt != 4'hF)
			rdyCnt <= rdyCnt + 4'h1;
	end

	always_comb begin
		sense.outputReady = softStartOn ? (rdyCnt >= 4'hA) :
			(pumpGain != lpmc_pkg::GAIN_NONE);
		// short sinks stay short until the gain reaches what they need
		sense.sinkLow  = (pumpGain < need) ? shortMask : '0;
		sense.sinkHigh = (pumpGain > need) ? '1 : ~shortMask;
		sense.fault    = faultIn;
	end
endmodule

// ---- tb/lpmc_top_test.sv ----
// self-checking bench for the pump, mode and level control block
// assumes the register port stands in for the serial receiver
`timescale 1ns/1ps
module lpmc_top_test;
	localparam int SETTLE = 20;
	logic                   mclk, rst, pinN, uv, regWrite, regRead;
	logic                   regAck, sawAck, faultIn;
	logic [7:0]             regAddr, regWdata, regRdata;
	logic [1:0]             pumpGain, need;
	logic [6:0]             levelCode, shortMask;
	logic [13:0]            sinkCurrent;
	logic                   softStartOn;
	logic [3:0]             swOr;
	lpmc_pkg::lpmc_sense_t  sense;
	lpmc_pkg::lpmc_switch_t pumpSwitch;
	int                     mismatches, compares, n;

	lpmc_top #(.SettleCycles(SETTLE)) lpmc_top_inst (.mclk(mclk), .rst(rst),
		.resetPinLowN(pinN), .undervoltageLockout(uv), .sense(sense),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
		.pumpGain(pumpGain), .softStartOn(softStartOn),
		.pumpSwitch(pumpSwitch), .levelCode(levelCode),
		.sinkCurrent(sinkCurrent));
	lpmc_pump_model lpmc_pump_model_inst (.mclk(mclk), .pumpGain(pumpGain),
		.softStartOn(softStartOn), .need(need), .shortMask(shortMask),
		.faultIn(faultIn), .sense(sense));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one access; request held one cycle, answer taken with the ack
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		regWrite = w;
		regRead  = !w;
		regAddr  = a;
		regWdata = d;
		@(negedge mclk);
		regWrite = 1'b0;
		regRead  = 1'b0;
		sawAck   = regAck;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(16'(sawAck), 16'h0001);
		chk(16'(regRdata), 16'(exp));
	endtask

	task automatic waitGain(input logic [1:0] g);
		n = 0;
		while (pumpGain !== g && n < 2000) begin
			@(negedge mclk);
			n++;
		end
	endtask

	task automatic collectSw();
		swOr = 4'h0;
		repeat (60) begin
			@(negedge mclk);
			swOr = swOr | pumpSwitch;
		end
	endtask

	initial begin
		{rst, pinN} = 2'h3;
		{uv, regWrite, regRead, faultIn} = 4'h0;
		{regAddr, regWdata} = 16'h0000;
		need = 2'h1;
		shortMask = 7'h01;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		rdc(lpmc_pkg::ADDR_LAW, 8'h00);
		rdc(lpmc_pkg::ADDR_MAX, 8'h00);
		rdc(8'h0F, 8'h00);
		$display("defaults done");
		acc(1'b1, lpmc_pkg::ADDR_MODE, 8'h01);
		@(negedge mclk);
		chk(16'(softStartOn), 16'h0001);
		chk(16'(pumpGain), 16'(lpmc_pkg::GAIN_NONE));
		acc(1'b1, lpmc_pkg::ADDR_SINK, 8'h7E);
		waitGain(lpmc_pkg::GAIN_1X);
		chk(16'(pumpSwitch.bypass), 16'h0001);
		need = 2'h3;
		repeat (3 * SETTLE) @(negedge mclk);
		chk(16'(pumpGain), 16'(lpmc_pkg::GAIN_1X));
		need = 2'h2;
		acc(1'b1, lpmc_pkg::ADDR_SINK, 8'h7F);
		waitGain(lpmc_pkg::GAIN_15X);
		chk(16'(pumpGain), 16'(lpmc_pkg::GAIN_15X));
		collectSw();
		chk(16'(swOr), 16'h0005);
		need = 2'h3;
		waitGain(lpmc_pkg::GAIN_2X);
		chk(16'(pumpGain), 16'(lpmc_pkg::GAIN_2X));
		collectSw();
		chk(16'(swOr), 16'h0003);
		need = 2'h1;
		waitGain(lpmc_pkg::GAIN_15X);
		waitGain(lpmc_pkg::GAIN_1X);
		chk(16'(n >= SETTLE - 2), 16'h0001);
		chk(16'(pumpGain), 16'(lpmc_pkg::GAIN_1X));
		faultIn = 1'b1;
		repeat (4) @(negedge mclk);
		chk(16'(pumpSwitch), 16'h0000);
		faultIn = 1'b0;
		// let the fault input clear through its synchroniser first
		repeat (2) @(negedge mclk);
		acc(1'b1, lpmc_pkg::ADDR_MODE, 8'h01);
		@(negedge mclk);
		chk(16'(softStartOn), 16'h0001);
		acc(1'b1, lpmc_pkg::ADDR_MODE, 8'h00);
		@(negedge mclk);
		chk(16'({softStartOn, pumpGain}), 16'h0000);
		$display("pump done");
		acc(1'b1, lpmc_pkg::ADDR_MODE, 8'h01);
		acc(1'b1, lpmc_pkg::ADDR_MAX, 8'h40);
		acc(1'b1, lpmc_pkg::ADDR_DIM, 8'h50);
		acc(1'b1, lpmc_pkg::ADDR_BL, 8'h01);
		repeat (3) @(negedge mclk);
		chk(16'(levelCode), 16'h0040);
		chk(16'(sinkCurrent), 16'h1FC0);
		acc(1'b1, lpmc_pkg::ADDR_BL, 8'h03);
		repeat (3) @(negedge mclk);
		chk(16'(levelCode), 16'h0050);
		acc(1'b1, lpmc_pkg::ADDR_BL, 8'h01);
		acc(1'b1, lpmc_pkg::ADDR_LAW, 8'h01);
		repeat (3) @(negedge mclk);
		chk(16'(levelCode), 16'h0040);
		chk(16'(sinkCurrent), 16'h1000);
		acc(1'b1, lpmc_pkg::ADDR_MAX, 8'h7F);
		repeat (3) @(negedge mclk);
		chk(16'(sinkCurrent), 16'h3F01);
		$display("levels done");
		pinN = 1'b0;
		repeat (lpmc_pkg::FILTER_CYCLES - 500) @(negedge mclk);
		pinN = 1'b1;
		repeat (4) @(negedge mclk);
		rdc(lpmc_pkg::ADDR_MAX, 8'h7F);
		pinN = 1'b0;
		repeat (lpmc_pkg::FILTER_CYCLES + 10) @(negedge mclk);
		acc(1'b0, lpmc_pkg::ADDR_MAX, 8'h00);
		chk(16'(sawAck), 16'h0000);
		chk(16'({levelCode, pumpGain}), 16'h0000);
		pinN = 1'b1;
		repeat (4) @(negedge mclk);
		rdc(lpmc_pkg::ADDR_MAX, 8'h00);
		$display("pin reset done");
		acc(1'b1, lpmc_pkg::ADDR_MAX, 8'h33);
		uv = 1'b1;
		repeat (5) @(negedge mclk);
		acc(1'b1, lpmc_pkg::ADDR_MAX, 8'h55);
		chk(16'(sawAck), 16'h0000);
		uv = 1'b0;
		repeat (4) @(negedge mclk);
		rdc(lpmc_pkg::ADDR_MAX, 8'h00);
		$display("undervoltage done");
		tally_and_finish();
	end

	// the run needs about 5000 cycles; allow a wide margin
	initial begin
		#1000000;
		mismatches++;
		tally_and_finish();
	end
endmodule
